// [logic/dso_defs.vh]
`ifndef DSO_DEFS_VH
`define DSO_DEFS_VH

// register byte offsets
`define DSO_OFS_CTRL      12'h000
`define DSO_OFS_STATUS    12'h004
`define DSO_OFS_PAR_ERR   12'h008
`define DSO_OFS_CC_ERR    12'h00C
`define DSO_OFS_PAT_ERR   12'h010
`define DSO_OFS_IRQ_STAT  12'h014
`define DSO_OFS_IRQ_MASK  12'h018

// control field positions
`define DSO_CTRL_AUTO_CLR 0
`define DSO_CTRL_PTE      1

// status field positions
`define DSO_ST_LOCKED     0
`define DSO_ST_WINDOW     1
`define DSO_ST_PAR        2
`define DSO_ST_CC         3
`define DSO_ST_PAT        4

// interrupt event positions
`define DSO_EV_PAR        0
`define DSO_EV_CC         1
`define DSO_EV_PAT        2
`define DSO_EV_LOCKLOSS   3
`define DSO_EV_WINDOW     4
`define DSO_EV_W          5

// reset values
`define DSO_RST_CTRL      2'h0
`define DSO_RST_MASK      5'h00

// good-alignment cycles needed before lock is reported
`define DSO_LOCK_QUAL     16

`endif

// [logic/dso_lock_tracker.v]
`timescale 1ns/1ns
`include "dso_defs.vh"

module dso_lock_tracker
#(
  parameter QUAL = `DSO_LOCK_QUAL
)
(
  // clock and reset
  input  wire mclk,
  input  wire reset_n,
  // lock sources
  input  wire enable,
  input  wire pllLocked,
  input  wire alignOk,
  input  wire alignBad,
  // result
  output wire locked
);

  reg  [7:0] qualCnt_q;
  reg        locked_q;
  wire       drop;

  // --------------------------------
  // lock search
  // --------------------------------
  assign drop = ~enable | ~pllLocked | alignBad;   // [R8] [R15]

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      qualCnt_q <= 8'h00;
      locked_q  <= 1'b0;
    end
    else if (drop)
    begin
      qualCnt_q <= 8'h00;   // search restarts from zero [R15]
      locked_q  <= 1'b0;
    end
    else if (alignOk && !locked_q)
    begin
      if (qualCnt_q == QUAL[7:0] - 8'h01)
        locked_q <= 1'b1;   // [R7]
      else
        qualCnt_q <= qualCnt_q + 8'h01;
    end
  end

  assign locked = locked_q;

endmodule // dso_lock_tracker

// [logic/dso_status_outputs.v]
// Functional notes
// R1 - power_down_n high powers the logic and enables every output.
// R2 - power_down_n low floats all outputs and idles the logic.
// R3 - link_fault_n driven low on parity, pattern or control-channel error.
// R4 - link_fault_n stays released high while no error is flagged.
// R5 - parity and control-channel faults clear when their error register is read.
// R6 - pattern fault clears only when pattern_test_enable returns to zero.
// R7 - link_locked high only when loops locked and word boundary aligned.
// R8 - link_locked low when loops unlock or misalignment is detected.
// R9 - control UART passed to ECU on ecu_uart_out; ECU input idles high.
// R10 - video delivered on sixteen-bit parallel output, bits 15 down to 0.
// R11 - recovered pixel clock output with frame and line sync aligned to it.
// R12 - ctrl_window_open raised at end of each video phase.
// R13 - with auto_error_reset zero, error counters reset on error register read; the pattern counter clears only when pattern_test_enable is zero.
// R14 - fault stays asserted until its own clear condition, even if error ends.
// R15 - lock reads not locked in power-down and search restarts afterwards.
`timescale 1ns/1ns
`include "dso_defs.vh"

module dso_status_outputs
#(
  parameter CNT_W = 8,
  parameter QUAL  = `DSO_LOCK_QUAL
)
(
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  output wire        irq,
  // power control
  input  wire        powerDownN,
  // recovered video from the link decoder
  input  wire        pixTick,
  input  wire [15:0] vidData,
  input  wire        vidFrameSync,
  input  wire        vidLineSync,
  // video pins
  output wire [15:0] parallelDataOut,
  output wire        pixelClkOut,
  output wire        frameSyncOut,
  output wire        lineSyncOut,
  output wire        videoOe,
  // error and lock sources
  input  wire        parityErr,
  input  wire        patternErr,
  input  wire        ctrlErr,
  input  wire        pllLocked,
  input  wire        alignOk,
  input  wire        alignBad,
  // open-drain status pins
  output wire        linkFaultNOut,
  output wire        linkFaultNOe,
  output wire        linkLockedOut,
  output wire        linkLockedOe,
  // control channel
  input  wire        videoPhaseEnd,
  input  wire        ctrlPhaseEnd,
  output wire        ctrlWindowOpen,
  output wire        ctrlWindowOe,
  input  wire        ecuUartIn,
  output wire        ecuUartOut,
  output wire        ecuUartOe,
  input  wire        linkUartRx,
  output wire        linkUartTx
);

  // --------------------------------
  // declarations
  // --------------------------------
  reg  [1:0]       ctrl_q;
  reg  [4:0]       irqMask_q;
  reg  [4:0]       irqStat_q;
  reg              parFault_q;
  reg              ccFault_q;
  reg              patFault_q;
  reg  [CNT_W-1:0] parCnt_q;
  reg  [CNT_W-1:0] ccCnt_q;
  reg  [CNT_W-1:0] patCnt_q;
  reg              window_q;
  reg              pixClk_q;
  reg  [15:0]      data_q;
  reg              fsync_q;
  reg              lsync_q;
  reg              lockedPrev_q;
  reg  [4:0]       events;
  wire             powered;
  wire             locked;
  wire             autoErrorReset;
  wire             patternTestEnable;
  wire             wrEn;
  wire             rdAcc;
  wire             setup;
  wire             mapped;
  wire             rdPar;
  wire             rdCc;
  wire             rdIrq;
  wire             anyFault;

  // saturating counter step
  function [CNT_W-1:0] satInc;
    input [CNT_W-1:0] v;
    begin
      satInc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // address decode
  function isMapped;
    input [11:0] a;
    begin
      isMapped = (a == `DSO_OFS_CTRL)     || (a == `DSO_OFS_STATUS)   ||
                 (a == `DSO_OFS_PAR_ERR)  || (a == `DSO_OFS_CC_ERR)   ||
                 (a == `DSO_OFS_PAT_ERR)  || (a == `DSO_OFS_IRQ_STAT) ||
                 (a == `DSO_OFS_IRQ_MASK);
    end
  endfunction

  assign powered           = powerDownN;   // [R1]
  assign autoErrorReset    = ctrl_q[`DSO_CTRL_AUTO_CLR];
  assign patternTestEnable = ctrl_q[`DSO_CTRL_PTE];

  // --------------------------------
  // apb slave
  // --------------------------------
  assign setup   = psel & ~penable;
  assign mapped  = isMapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wrEn    = psel & penable & pwrite & mapped;
  assign rdAcc   = psel & penable & ~pwrite;
  assign rdPar   = rdAcc & (paddr == `DSO_OFS_PAR_ERR);
  assign rdCc    = rdAcc & (paddr == `DSO_OFS_CC_ERR);
  assign rdIrq   = rdAcc & (paddr == `DSO_OFS_IRQ_STAT);

  always @(posedge mclk)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `DSO_OFS_CTRL:     prdata <= {30'h0000_0000, ctrl_q};
        `DSO_OFS_STATUS:   prdata <= {27'h000_0000, patFault_q, ccFault_q, parFault_q, window_q, locked};
        `DSO_OFS_PAR_ERR:  prdata <= {{(32-CNT_W){1'b0}}, parCnt_q};
        `DSO_OFS_CC_ERR:   prdata <= {{(32-CNT_W){1'b0}}, ccCnt_q};
        `DSO_OFS_PAT_ERR:  prdata <= {{(32-CNT_W){1'b0}}, patCnt_q};
        `DSO_OFS_IRQ_STAT: prdata <= {27'h000_0000, irqStat_q};
        `DSO_OFS_IRQ_MASK: prdata <= {27'h000_0000, irqMask_q};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_q    <= `DSO_RST_CTRL;
      irqMask_q <= `DSO_RST_MASK;
    end
    else if (wrEn)
    begin
      if (paddr == `DSO_OFS_CTRL)
        ctrl_q <= pwdata[1:0];
      if (paddr == `DSO_OFS_IRQ_MASK)
        irqMask_q <= pwdata[4:0];
    end
  end

  // --------------------------------
  // error flags and counters
  // --------------------------------
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      parFault_q <= 1'b0;
      ccFault_q  <= 1'b0;
      patFault_q <= 1'b0;
    end
    else
    begin
      // sticky until own clear; a new parity or control-channel error wins over the clear, the pattern clear wins [R14]
      if (powered && parityErr)
        parFault_q <= 1'b1;   // [R3]
      else if (rdPar)
        parFault_q <= 1'b0;   // [R5]
      if (powered && ctrlErr)
        ccFault_q <= 1'b1;    // [R3]
      else if (rdCc)
        ccFault_q <= 1'b0;    // [R5]
      if (!patternTestEnable)
        patFault_q <= 1'b0;   // [R6]
      else if (powered && patternErr)
        patFault_q <= 1'b1;   // [R3]
    end
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      parCnt_q <= {CNT_W{1'b0}};
      ccCnt_q  <= {CNT_W{1'b0}};
      patCnt_q <= {CNT_W{1'b0}};
    end
    else
    begin
      if (powered && parityErr)
        parCnt_q <= (rdPar && !autoErrorReset) ? {{(CNT_W-1){1'b0}}, 1'b1} : satInc(parCnt_q);
      else if (rdPar && !autoErrorReset)
        parCnt_q <= {CNT_W{1'b0}};   // [R13]
      if (powered && ctrlErr)
        ccCnt_q <= (rdCc && !autoErrorReset) ? {{(CNT_W-1){1'b0}}, 1'b1} : satInc(ccCnt_q);
      else if (rdCc && !autoErrorReset)
        ccCnt_q <= {CNT_W{1'b0}};    // [R13]
      if (!patternTestEnable)
        patCnt_q <= {CNT_W{1'b0}};
      else if (powered && patternErr)
        patCnt_q <= satInc(patCnt_q);
    end
  end

  assign anyFault      = parFault_q | ccFault_q | patFault_q;
  assign linkFaultNOut = 1'b0;
  assign linkFaultNOe  = powered & anyFault;   // [R3] [R4] [R2]

  // --------------------------------
  // lock
  // --------------------------------
  dso_lock_tracker #(
    .QUAL      (QUAL)
  ) u_lock (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .enable    (powered),
    .pllLocked (pllLocked),
    .alignOk   (alignOk),
    .alignBad  (alignBad),
    .locked    (locked)
  );

  assign linkLockedOut = 1'b0;
  assign linkLockedOe  = powered & ~locked;   // [R7] [R8] [R2]

  // --------------------------------
  // video outputs
  // --------------------------------
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pixClk_q <= 1'b0;
      data_q   <= 16'h0000;
      fsync_q  <= 1'b0;
      lsync_q  <= 1'b0;
    end
    else if (!powered)
      pixClk_q <= 1'b0;
    else if (pixTick)
    begin
      pixClk_q <= ~pixClk_q;   // [R11]
      if (!pixClk_q)
      begin
        data_q  <= vidData;    // [R10]
        fsync_q <= vidFrameSync;   // [R11]
        lsync_q <= vidLineSync;
      end
    end
  end

  assign parallelDataOut = data_q;
  assign pixelClkOut     = pixClk_q;
  assign frameSyncOut    = fsync_q;
  assign lineSyncOut     = lsync_q;
  assign videoOe         = powered;   // [R1] [R2]

  // --------------------------------
  // control channel
  // --------------------------------
  always @(posedge mclk)
  begin
    if (!reset_n)
      window_q <= 1'b0;
    else if (!powered)
      window_q <= 1'b0;
    else if (videoPhaseEnd)
      window_q <= 1'b1;   // [R12]
    else if (ctrlPhaseEnd)
      window_q <= 1'b0;
  end

  assign ctrlWindowOpen = window_q;
  assign ctrlWindowOe   = powered;
  assign ecuUartOut     = window_q ? linkUartRx : 1'b1;   // [R9]
  assign ecuUartOe      = powered;                        // [R9] [R2]
  assign linkUartTx     = (powered && window_q) ? ecuUartIn : 1'b1;   // [R9]

  // --------------------------------
  // interrupts
  // --------------------------------
  always @*
  begin
    events = 5'h00;
    events[`DSO_EV_PAR]      = powered & parityErr;
    events[`DSO_EV_CC]       = powered & ctrlErr;
    events[`DSO_EV_PAT]      = powered & patternErr & patternTestEnable;
    events[`DSO_EV_LOCKLOSS] = lockedPrev_q & ~locked;
    events[`DSO_EV_WINDOW]   = powered & videoPhaseEnd & ~window_q;
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      irqStat_q    <= 5'h00;
      lockedPrev_q <= 1'b0;
    end
    else
    begin
      lockedPrev_q <= locked;
      irqStat_q    <= (rdIrq ? 5'h00 : irqStat_q) | events;
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

endmodule // dso_status_outputs

// [testbench/dso_status_chk.sv]
`timescale 1ns/1ns
// ----
// port checker
// ----
module dso_status_chk
(
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // watched ports
  input wire psel,
  input wire penable,
  input wire pready,
  input wire powerDownN,
  input wire videoOe,
  input wire parityErr,
  input wire alignBad,
  input wire videoPhaseEnd,
  input wire linkFaultNOe,
  input wire linkLockedOe,
  input wire ctrlWindowOpen,
  input wire ecuUartOut,
  input wire pixelClkOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  power_oe_a: assert property (videoOe == powerDownN) else $error("video enable wrong");
  float_pins_a: assert property (!powerDownN |-> !linkFaultNOe && !linkLockedOe) else $error("pin driven");
  fault_set_a: assert property (parityErr && powerDownN |=> linkFaultNOe) else $error("no fault");
  fault_idle_a: assert property ($rose(reset_n) |-> !linkFaultNOe) else $error("fault after reset");
  lock_bad_a: assert property (alignBad && powerDownN |-> ##[1:2] linkLockedOe) else $error("lock held");
  lock_down_a: assert property ($rose(powerDownN) |-> linkLockedOe [*2]) else $error("lock kept");
  uart_idle_a: assert property (!ctrlWindowOpen |-> ecuUartOut) else $error("uart not idle");
  window_set_a: assert property (videoPhaseEnd && powerDownN |=> ctrlWindowOpen) else $error("no window");
  pclk_stop_a: assert property (!powerDownN |=> !pixelClkOut) else $error("pixel clock runs");
  apb_ready_a: assert property (psel && penable |-> pready) else $error("pready low");
endmodule // dso_status_chk
bind dso_status_outputs dso_status_chk chk_u (.mclk, .reset_n, .psel, .penable, .pready, .powerDownN, .videoOe,
  .parityErr, .alignBad, .videoPhaseEnd, .linkFaultNOe, .linkLockedOe, .ctrlWindowOpen, .ecuUartOut, .pixelClkOut);

// [testbench/dso_far_side.sv]
`timescale 1ns/1ns
// ----
// serializer and ecu model
// ----
module dso_far_side
(
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // recovered video
  output reg         pixTick,
  output reg  [15:0] vidData,
  output reg         vidFrameSync,
  output reg         vidLineSync,
  // uart lines
  output reg         ecuUartIn,
  output reg         linkUartRx
);
  reg [7:0] cnt_q;
  initial {pixTick, vidData, vidFrameSync, vidLineSync, ecuUartIn, linkUartRx} = 21'h1FFFFF;
  always @(posedge mclk)
  begin
    cnt_q <= reset_n ? cnt_q + 8'h01 : 8'h00;
    pixTick <= cnt_q[0];
    vidData <= {cnt_q, ~cnt_q};
    vidFrameSync <= cnt_q[4];
    vidLineSync <= cnt_q[1];
    ecuUartIn <= ~cnt_q[2];
    linkUartRx <= cnt_q[3];
  end
endmodule // dso_far_side

// [testbench/dso_status_outputs_tb.sv]
`timescale 1ns/1ns
`include "dso_defs.vh"
module dso_status_outputs_tb;
  // ----
  // signals
  // ----
  reg         mclk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg         powerDownN = 1'h1, pllLocked = 1'h0, alignOk = 1'h0, alignBad = 1'h0, err, pcPrev;
  reg  [4:0]  ev = 5'h00;
  reg  [17:0] prevVid;
  reg  [29:0] rows [0:9];
  reg         vidOn = 1'h0, winOn = 1'h0;
  integer     nMismatch = 0, checked = 0, vidN = 0, i, k;
  wire        pready, pslverr, irq, pixelClkOut, frameSyncOut, lineSyncOut, videoOe, linkFaultNOut;
  wire        linkFaultNOe, linkLockedOut, linkLockedOe, ctrlWindowOpen, ctrlWindowOe, ecuUartOut, ecuUartOe;
  wire        linkUartTx, pixTick, vidFrameSync, vidLineSync, ecuUartIn, linkUartRx;
  wire [31:0] prdata;
  wire [15:0] parallelDataOut, vidData;
  wire        faultPin = linkFaultNOe ? linkFaultNOut : 1'h1;
  wire        lockPin = linkLockedOe ? linkLockedOut : 1'h1;
  always #50 mclk = ~mclk;
  dso_far_side far_u (.mclk, .reset_n, .pixTick, .vidData, .vidFrameSync, .vidLineSync, .ecuUartIn, .linkUartRx);
  dso_status_outputs #(.CNT_W(8), .QUAL(4)) dut_u (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .irq, .powerDownN, .pixTick, .vidData, .vidFrameSync, .vidLineSync,
    .parallelDataOut, .pixelClkOut, .frameSyncOut, .lineSyncOut, .videoOe, .parityErr(ev[0]), .ctrlErr(ev[1]),
    .patternErr(ev[2]), .pllLocked, .alignOk, .alignBad, .linkFaultNOut, .linkFaultNOe, .linkLockedOut,
    .linkLockedOe, .videoPhaseEnd(ev[3]), .ctrlPhaseEnd(ev[4]), .ctrlWindowOpen, .ctrlWindowOe, .ecuUartIn,
    .ecuUartOut, .ecuUartOe, .linkUartRx, .linkUartTx);
  // ----
  // tasks
  // ----
  task check(input string name, input [39:0] seen, input [39:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      nMismatch = nMismatch + 1;
      $display("BAD %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
  begin
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    t = 0;
    do
    begin
      @(posedge mclk);
      t = t + 1;
    end
    while (pready !== 1'h1 && t < 20);
    if (t >= 20)
      nMismatch = nMismatch + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge mclk);
  end
  endtask
  task pulse(input [4:0] m);
  begin
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 5'h00;
    @(negedge mclk);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // ----
  // monitors and watchdog
  // ----
  always @(posedge mclk) prevVid <= {vidFrameSync, vidLineSync, vidData};
  always @(negedge mclk)
  begin
    if (vidOn && pixelClkOut && !pcPrev)
    begin
      check("video", {frameSyncOut, lineSyncOut, parallelDataOut}, prevVid);
      vidN = vidN + 1;
    end
    pcPrev = pixelClkOut;
    if (winOn)
      check("uart", {ecuUartOut, linkUartTx}, {linkUartRx, ecuUartIn});
  end
  initial
  begin
    #300000;
    nMismatch = nMismatch + 1;
    conclude;
  end
  // ----
  // tests
  // ----
  initial
  begin
    rows[0] = {1'h0, `DSO_OFS_CTRL, 8'h00, 8'h00, 1'h0};
    rows[1] = {1'h0, `DSO_OFS_STATUS, 8'h00, 8'h00, 1'h0};
    rows[2] = {1'h0, `DSO_OFS_CC_ERR, 8'h00, 8'h00, 1'h0};
    rows[3] = {1'h0, `DSO_OFS_IRQ_STAT, 8'h00, 8'h00, 1'h0};
    rows[4] = {1'h1, `DSO_OFS_IRQ_MASK, 8'hFF, 8'h1F, 1'h0};
    rows[5] = {1'h1, `DSO_OFS_STATUS, 8'hFF, 8'h00, 1'h0};
    rows[6] = {1'h1, 12'h0FC, 8'hFF, 8'h00, 1'h1};
    rows[7] = {1'h1, `DSO_OFS_CTRL, 8'hFF, 8'h03, 1'h0};
    rows[8] = {1'h1, `DSO_OFS_CTRL, 8'h00, 8'h00, 1'h0};
    rows[9] = {1'h1, `DSO_OFS_IRQ_MASK, 8'h00, 8'h00, 1'h0};
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    for (i = 0; i < 10; i = i + 1)
    begin
      if (rows[i][29])
        apb(1'h1, rows[i][28:17], {24'h0, rows[i][16:9]});
      apb(1'h0, rows[i][28:17], 32'h0);
      check("reg", rd, {24'h0, rows[i][8:1]});
      check("slverr", err, rows[i][0]);
    end
    $display("test registers done");
    @(posedge mclk);
    powerDownN <= 1'h0;
    @(negedge mclk);
    check("float", {videoOe, ctrlWindowOe, ecuUartOe, linkFaultNOe, linkLockedOe}, 5'h00);
    @(posedge mclk);
    powerDownN <= 1'h1;
    @(negedge mclk);
    check("drive", {videoOe, ctrlWindowOe, ecuUartOe}, 3'h7);
    vidOn = 1'h1;
    repeat (32) @(posedge mclk);
    vidOn = 1'h0;
    check("video count", vidN > 5, 1'h1);
    pulse(5'h18);
    check("window", ctrlWindowOpen, 1'h1);
    winOn = 1'h1;
    repeat (10) @(negedge mclk);
    winOn = 1'h0;
    pulse(5'h10);
    check("closed", {ctrlWindowOpen, ecuUartOut}, 2'h1);
    $display("test power video window done");
    for (k = 0; k < 2; k = k + 1)
    begin
      pulse(5'h01 << k);
      repeat (3) @(negedge mclk);
      check("fault", faultPin, 1'h0);
      apb(1'h0, k ? `DSO_OFS_CC_ERR : `DSO_OFS_PAR_ERR, 32'h0);
      check("count", rd, 32'h1);
      @(negedge mclk);
      check("fault clear", faultPin, 1'h1);
      apb(1'h0, k ? `DSO_OFS_CC_ERR : `DSO_OFS_PAR_ERR, 32'h0);
      check("count clear", rd, 32'h0);
    end
    apb(1'h1, `DSO_OFS_CTRL, 32'h1);
    pulse(5'h01);
    pulse(5'h01);
    for (k = 0; k < 2; k = k + 1)
    begin
      apb(1'h0, `DSO_OFS_PAR_ERR, 32'h0);
      check("count kept", rd, 32'h2);
    end
    apb(1'h1, `DSO_OFS_CTRL, 32'h0);
    pulse(5'h04);
    check("pattern off", faultPin, 1'h1);
    apb(1'h1, `DSO_OFS_CTRL, 32'h2);
    pulse(5'h04);
    apb(1'h0, `DSO_OFS_PAT_ERR, 32'h0);
    @(negedge mclk);
    check("pattern held", {faultPin, rd}, 33'h1);
    apb(1'h1, `DSO_OFS_CTRL, 32'h0);
    @(negedge mclk);
    check("pattern clear", faultPin, 1'h1);
    apb(1'h0, `DSO_OFS_IRQ_STAT, 32'h0);
    apb(1'h1, `DSO_OFS_IRQ_MASK, 32'h1);
    pulse(5'h01);
    check("irq on", irq, 1'h1);
    apb(1'h1, `DSO_OFS_IRQ_MASK, 32'h0);
    check("irq masked", irq, 1'h0);
    apb(1'h1, `DSO_OFS_IRQ_MASK, 32'h1);
    apb(1'h0, `DSO_OFS_IRQ_STAT, 32'h0);
    check("irq stat", {irq, rd}, 33'h1);
    $display("test faults irq done");
    @(posedge mclk);
    pllLocked <= 1'h1;
    alignOk <= 1'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("unqualified", lockPin, 1'h0);
    @(negedge mclk);
    check("locked", lockPin, 1'h1);
    @(posedge mclk);
    alignBad <= 1'h1;
    @(posedge mclk);
    alignBad <= 1'h0;
    repeat (2) @(negedge mclk);
    check("misaligned", lockPin, 1'h0);
    repeat (6) @(posedge mclk);
    pllLocked <= 1'h0;
    repeat (2) @(negedge mclk);
    check("unlocked", lockPin, 1'h0);
    @(posedge mclk);
    pllLocked <= 1'h1;
    repeat (5) @(negedge mclk);
    check("relock", lockPin, 1'h1);
    @(posedge mclk);
    powerDownN <= 1'h0;
    apb(1'h0, `DSO_OFS_STATUS, 32'h0);
    check("down lock", rd[`DSO_ST_LOCKED], 1'h0);
    @(posedge mclk);
    powerDownN <= 1'h1;
    @(negedge mclk);
    check("restart", lockPin, 1'h0);
    repeat (6) @(negedge mclk);
    check("relocked", lockPin, 1'h1);
    pulse(5'h01);
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    @(negedge mclk);
    check("reset fault", faultPin, 1'h1);
    $display("test lock reset done");
    conclude;
  end
endmodule // dso_status_outputs_tb
